// ===== hw/rxp_consts.svh
`ifndef RXP_CONSTS_SVH
`define RXP_CONSTS_SVH
// ----------------------------------------------------------------
// buffer geometry
// ----------------------------------------------------------------
`define RXP_NBUF 2
`define RXP_DEPTH 8
`define RXP_QUARTER 4'h2
`define RXP_FULL 4'h8
`define RXP_DIV_LAST 2'h3
`define RXP_TAP_MAX 3'h6
`define RXP_STAT_STARVING 2'h0
`define RXP_STAT_SATISFIED 2'h2
// ----------------------------------------------------------------
// host register offsets (byte addresses)
// ----------------------------------------------------------------
`define RXP_OFF_CTRL 20'h00000
`define RXP_OFF_STCMD 20'h00004
`define RXP_OFF_RDCMD 20'h00008
`define RXP_OFF_DATLO 20'h0000c
`define RXP_OFF_DATHI 20'h00010
`define RXP_OFF_MARK 20'h00014
`define RXP_OFF_IRQST 20'h00018
`define RXP_OFF_IRQMSK 20'h0001c
`define RXP_OFF_EMPTYSEL 20'h30920
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RXP_CTRL_EXT 0
`define RXP_CTRL_INSERT 1
`define RXP_CTRL_DYN 2
`define RXP_CTRL_STOP0 3
`define RXP_CTRL_STOP1 4
`define RXP_CTRL_TAP_LO 5
`define RXP_CTRL_TAP_HI 7
`define RXP_RD_BUF 3
`define RXP_IRQ_DONE 0
`define RXP_IRQ_REFUSED 1
`define RXP_IRQ_ERR 2
`endif

// ===== hw/rxp_pkg.sv
package rxp_pkg;
  // one stored word with its markers
  typedef struct packed {
    logic ctl;
    logic sop;
    logic eop;
    logic err;
    logic [7:0] be;
    logic [63:0] data;
  } rxp_word_t;

  // host read sequencer, one-hot
  typedef enum logic [2:0] {
    RXP_IDLE = 3'b001,
    RXP_ISSUE = 3'b010,
    RXP_CAPTURE = 3'b100
  } rxp_hstate_t;
endpackage : rxp_pkg

// ===== hw/rxp_if.sv
`timescale 1ns/1ps
interface rxp_if;
  // buffer read ports, one element per buffer
  logic [1:0][2:0] buffer_read_address;
  logic [1:0] buffer_read_enable;
  logic [1:0][63:0] buffer_read_word;
  logic [1:0][7:0] buffer_byte_enables;
  logic [1:0] buffer_port_id_marker;
  logic [1:0] buffer_packet_start;
  logic [1:0] buffer_packet_end;
  logic [1:0] buffer_word_error;
  logic [1:0] buffer_empty_flag;
  logic [1:0] buffer_end_stop_control;
  logic [1:0] empty_flag_type_select;
  // status memory and misc controls
  logic [7:0] status_port_number;
  logic [1:0] port_flow_status_in;
  logic status_mem_write_enable;
  logic status_mem_write_clock;
  logic external_status_select;
  logic rx_clock_delay_insert;
  logic [2:0] rx_clock_delay_tap;
  logic rx_status_quarter_clock;

  modport dev (
    input buffer_read_address, buffer_read_enable, buffer_end_stop_control,
    input empty_flag_type_select, status_port_number, port_flow_status_in,
    input status_mem_write_enable, status_mem_write_clock,
    input external_status_select, rx_clock_delay_insert, rx_clock_delay_tap,
    output buffer_read_word, buffer_byte_enables, buffer_port_id_marker,
    output buffer_packet_start, buffer_packet_end, buffer_word_error,
    output buffer_empty_flag, rx_status_quarter_clock
  );
  modport usr (
    output buffer_read_address, buffer_read_enable, buffer_end_stop_control,
    output empty_flag_type_select, status_port_number, port_flow_status_in,
    output status_mem_write_enable, status_mem_write_clock,
    output external_status_select, rx_clock_delay_insert, rx_clock_delay_tap,
    input buffer_read_word, buffer_byte_enables, buffer_port_id_marker,
    input buffer_packet_start, buffer_packet_end, buffer_word_error,
    input buffer_empty_flag, rx_status_quarter_clock
  );
endinterface : rxp_if

// ===== hw/rxp_buffer.sv
`timescale 1ns/1ps
`include "rxp_consts.svh"
module rxp_buffer (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic push,
  input wire rxp_pkg::rxp_word_t push_word,
  output logic push_ready,
  input wire logic rd_en,
  input wire logic [2:0] rd_addr,
  input wire logic type_sel,
  input wire logic end_stop,
  output rxp_pkg::rxp_word_t rd_word,
  output logic empty_flag
);
  import rxp_pkg::*;

  typedef struct packed {
    rxp_word_t [7:0] mem;
    logic [2:0] wr_ptr;
    logic [3:0] count;
    rxp_word_t word;
    logic empty;
    logic ready;
  } rxp_buf_state_t;

  rxp_buf_state_t st_r;
  rxp_buf_state_t st_nxt;
  logic do_push;
  logic do_pop;

  // ----------------------------------------------------------------
  // next state: store, read by address, fill level, flags
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    do_push = push && st_r.ready;
    do_pop = rd_en && (st_r.count != 4'h0);
    if (do_push)
    begin
      st_nxt.mem[st_r.wr_ptr] = push_word;
      st_nxt.wr_ptr = st_r.wr_ptr + 3'h1;
    end
    if (do_pop)
      st_nxt.word = st_r.mem[rd_addr]; // word and markers next cycle
    if (do_push && !do_pop)
      st_nxt.count = st_r.count + 4'h1;
    else if (do_pop && !do_push)
      st_nxt.count = st_r.count - 4'h1;
    st_nxt.ready = (st_nxt.count != `RXP_FULL);
    if (type_sel)
      st_nxt.empty = (st_nxt.count < `RXP_QUARTER);
    else
      st_nxt.empty = (st_nxt.count == 4'h0);
    // hold reads off at a packet end while the stop control is set
    if (end_stop && st_nxt.word.eop)
      st_nxt.empty = 1'b1;
  end

  // state register
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      st_r <= '0;
      st_r.empty <= 1'b1;
      st_r.ready <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  assign push_ready = st_r.ready;
  assign rd_word = st_r.word;
  assign empty_flag = st_r.empty;
endmodule : rxp_buffer

// ===== hw/rxp_device.sv
`timescale 1ns/1ps
`include "rxp_consts.svh"
module rxp_device (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // buffer read ports and status inputs from the user side
  rxp_if.dev lnk,
  // line-side words entering the buffers
  input wire logic in_valid,
  input wire logic in_buffer,
  input wire rxp_pkg::rxp_word_t in_word,
  output logic [1:0] in_ready,
  // receive data clock, one pulse per clock
  input wire logic rx_data_clock_tick,
  // status sent toward the link and delay line controls
  output logic [1:0] link_status,
  output logic [7:0] link_status_port,
  output logic delay_insert,
  output logic [2:0] delay_tap
);
  import rxp_pkg::*;

  // ----------------------------------------------------------------
  // state of the status side
  // ----------------------------------------------------------------
  typedef struct packed {
    // flow-control status, one entry per logical port
    logic [255:0][1:0] stat_mem;

    // quarter-rate divider and its enable
    logic [1:0] div_cnt;
    logic quarter;

    // calendar position and what it last sent
    logic [7:0] cal_idx;
    logic [1:0] link_status;
    logic [7:0] link_port;

    // delay line controls as applied
    logic delay_insert;
    logic [2:0] delay_tap;
  } rxp_dev_state_t;

  rxp_dev_state_t st_r;
  rxp_dev_state_t st_nxt;

  // per-buffer outputs gathered for the read ports
  rxp_word_t [1:0] rd_word;
  logic [1:0] buf_ready;
  logic [1:0] empty_flag;
  logic [1:0] push_sel;

  // status code of the buffer the calendar points at
  logic [1:0] internal_status;

  // ----------------------------------------------------------------
  // decoding for the calendar and the delay line
  // ----------------------------------------------------------------
  // ports map onto buffers by their lowest bit
  function automatic logic cal_buffer(input logic [7:0] port);
  begin
    return port[0];
  end
  endfunction : cal_buffer

  // no room left in a buffer means satisfied, else starving
  function automatic logic [1:0] room_status(input logic room);
  begin
    if (room)
      return `RXP_STAT_STARVING;
    else
      return `RXP_STAT_SATISFIED;
  end
  endfunction : room_status

  // a tap of seven is outside the delay line's range
  function automatic logic tap_legal(input logic [2:0] tap);
  begin
    return (tap <= `RXP_TAP_MAX);
  end
  endfunction : tap_legal

  // ----------------------------------------------------------------
  // packet buffers, one per read port
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `RXP_NBUF; gi = gi + 1)
    begin : g_buf
      // push strobe steered to this buffer only
      assign push_sel[gi] = in_valid && (in_buffer == 1'(gi));

      rxp_buffer rxp_buffer_i (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .push(push_sel[gi]),
        .push_word(in_word),
        .push_ready(buf_ready[gi]),
        .rd_en(lnk.buffer_read_enable[gi]),
        .rd_addr(lnk.buffer_read_address[gi]),
        .type_sel(lnk.empty_flag_type_select[gi]),
        .end_stop(lnk.buffer_end_stop_control[gi]),
        .rd_word(rd_word[gi]),
        .empty_flag(empty_flag[gi])
      );

      // word and byte enables straight from buffer flops
      assign lnk.buffer_read_word[gi] = rd_word[gi].data;
      assign lnk.buffer_byte_enables[gi] = rd_word[gi].be;

      // markers travel with the word they describe
      assign lnk.buffer_port_id_marker[gi] = rd_word[gi].ctl;
      assign lnk.buffer_packet_start[gi] = rd_word[gi].sop;
      assign lnk.buffer_packet_end[gi] = rd_word[gi].eop;
      assign lnk.buffer_word_error[gi] = rd_word[gi].err;

      // empty flag as the buffer computes it
      assign lnk.buffer_empty_flag[gi] = empty_flag[gi];
    end
  endgenerate

  // ----------------------------------------------------------------
  // internal status: a full buffer reports satisfied
  // ----------------------------------------------------------------
  always_comb
  begin
    internal_status = room_status(buf_ready[cal_buffer(st_r.cal_idx)]);
  end

  // ----------------------------------------------------------------
  // next state: divider, status memory, calendar, delay line
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;

    // divide the receive data clock by four into a one-cycle enable
    st_nxt.quarter = 1'b0;
    if (rx_data_clock_tick)
    begin
      st_nxt.div_cnt = st_r.div_cnt + 2'h1;
      if (st_r.div_cnt == `RXP_DIV_LAST)
        st_nxt.quarter = 1'b1;
    end

    // user writes go into the per-port status memory
    if (lnk.status_mem_write_clock && lnk.status_mem_write_enable)
      st_nxt.stat_mem[lnk.status_port_number] =
        lnk.port_flow_status_in;

    // calendar walks all ports, one per quarter-rate enable
    if (st_r.quarter)
    begin
      st_nxt.link_port = st_r.cal_idx;
      if (lnk.external_status_select)
        st_nxt.link_status = st_r.stat_mem[st_r.cal_idx];
      else
        st_nxt.link_status = internal_status;
      st_nxt.cal_idx = st_r.cal_idx + 8'h1;
    end

    // delay line controls: insert or bypass
    st_nxt.delay_insert = lnk.rx_clock_delay_insert;
    // a tap of seven is illegal and leaves the last good tap in place
    if (tap_legal(lnk.rx_clock_delay_tap))
      st_nxt.delay_tap = lnk.rx_clock_delay_tap;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // ----------------------------------------------------------------
  // outputs, all from flops
  // ----------------------------------------------------------------
  assign in_ready = buf_ready;
  assign link_status = st_r.link_status;
  assign link_status_port = st_r.link_port;
  assign delay_insert = st_r.delay_insert;
  assign delay_tap = st_r.delay_tap;
  assign lnk.rx_status_quarter_clock = st_r.quarter;
endmodule : rxp_device

// ===== hw/rxp_host.sv
`timescale 1ns/1ps
`include "rxp_consts.svh"
module rxp_host (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [19:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  rxp_if.usr lnk
);
  import rxp_pkg::*;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [1:0] empty_sel;
    logic [7:0] port_num;
    logic [1:0] port_stat;
    logic stat_we;
    logic [1:0] rd_en;
    logic [2:0] rd_addr;
    logic rd_buf;
    rxp_hstate_t fsm;
    logic [63:0] dat;
    logic [11:0] mark;
    logic [2:0] irq_st;
    logic [2:0] irq_mask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } rxp_host_state_t;

  rxp_host_state_t st_r;
  rxp_host_state_t st_nxt;
  logic setup;
  logic wr_acc;
  logic rd_acc;
  logic [2:0] irq_set;
  logic [2:0] tap_in;

  // ----------------------------------------------------------------
  // apb slave, read sequencer, status writes, interrupts
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    irq_set = 3'h0;
    setup = psel && !penable;
    wr_acc = psel && penable && st_r.pready && pwrite;
    rd_acc = psel && penable && st_r.pready && !pwrite;
    tap_in = pwdata[`RXP_CTRL_TAP_HI:`RXP_CTRL_TAP_LO];
    st_nxt.pready = setup;
    st_nxt.stat_we = 1'b0;
    st_nxt.rd_en = 2'h0;
    if (setup)
    begin
      st_nxt.pslverr = 1'b0;
      unique case (paddr)
        `RXP_OFF_CTRL: st_nxt.prdata = {24'h0, st_r.ctrl};
        `RXP_OFF_STCMD: st_nxt.prdata = {22'h0, st_r.port_stat, st_r.port_num};
        `RXP_OFF_RDCMD: st_nxt.prdata = {28'h0, st_r.rd_buf, st_r.rd_addr};
        `RXP_OFF_DATLO: st_nxt.prdata = st_r.dat[31:0];
        `RXP_OFF_DATHI: st_nxt.prdata = st_r.dat[63:32];
        `RXP_OFF_MARK: st_nxt.prdata = {20'h0, st_r.mark};
        `RXP_OFF_IRQST: st_nxt.prdata = {29'h0, st_r.irq_st};
        `RXP_OFF_IRQMSK: st_nxt.prdata = {29'h0, st_r.irq_mask};
        `RXP_OFF_EMPTYSEL: st_nxt.prdata = {30'h0, st_r.empty_sel};
        default:
        begin
          st_nxt.prdata = 32'h0;
          st_nxt.pslverr = 1'b1;
        end
      endcase
    end
    if (wr_acc)
    begin
      unique case (paddr)
        `RXP_OFF_CTRL:
        begin
          st_nxt.ctrl = pwdata[7:0];
          // illegal tap saturates to the highest legal one
          if (tap_in > `RXP_TAP_MAX)
            st_nxt.ctrl[`RXP_CTRL_TAP_HI:`RXP_CTRL_TAP_LO] =
              `RXP_TAP_MAX;
        end
        `RXP_OFF_STCMD:
        begin
          st_nxt.port_num = pwdata[7:0];
          st_nxt.port_stat = pwdata[9:8];
          st_nxt.stat_we = 1'b1;
        end
        `RXP_OFF_RDCMD:
        begin
          // refuse a read on an empty buffer or while one is in flight
          if (lnk.buffer_empty_flag[pwdata[`RXP_RD_BUF]] ||
              (st_r.fsm != RXP_IDLE))
            irq_set[`RXP_IRQ_REFUSED] = 1'b1;
          else
          begin
            st_nxt.rd_addr = pwdata[2:0];
            st_nxt.rd_buf = pwdata[`RXP_RD_BUF];
            st_nxt.rd_en[pwdata[`RXP_RD_BUF]] = 1'b1;
            st_nxt.fsm = RXP_ISSUE;
          end
        end
        `RXP_OFF_IRQMSK: st_nxt.irq_mask = pwdata[2:0];
        `RXP_OFF_EMPTYSEL: st_nxt.empty_sel = pwdata[1:0];
        default: st_nxt.irq_mask = st_r.irq_mask;
      endcase
    end
    // sample the word the cycle after the read was issued
    unique case (st_r.fsm)
      RXP_IDLE: st_nxt.fsm = st_nxt.fsm;
      RXP_ISSUE: st_nxt.fsm = RXP_CAPTURE;
      RXP_CAPTURE:
      begin
        st_nxt.dat = lnk.buffer_read_word[st_r.rd_buf];
        st_nxt.mark = {lnk.buffer_port_id_marker[st_r.rd_buf],
                       lnk.buffer_word_error[st_r.rd_buf],
                       lnk.buffer_packet_end[st_r.rd_buf],
                       lnk.buffer_packet_start[st_r.rd_buf],
                       lnk.buffer_byte_enables[st_r.rd_buf]};
        irq_set[`RXP_IRQ_DONE] = 1'b1;
        irq_set[`RXP_IRQ_ERR] = lnk.buffer_word_error[st_r.rd_buf];
        st_nxt.fsm = RXP_IDLE;
      end
    endcase
    // read clears only the bits it reported, a new event wins
    if (rd_acc && (paddr == `RXP_OFF_IRQST))
      st_nxt.irq_st = (st_r.irq_st & ~st_r.prdata[2:0]) | irq_set;
    else
      st_nxt.irq_st = st_r.irq_st | irq_set;
    st_nxt.irq = |(st_nxt.irq_st & st_nxt.irq_mask);
  end

  // state register
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      st_r <= '0;
      st_r.fsm <= RXP_IDLE;
    end
    else
      st_r <= st_nxt;
  end

  // ----------------------------------------------------------------
  // outputs from flops, except the delay insert select, gated from two ctrl bits
  // ----------------------------------------------------------------
  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign irq = st_r.irq;
  assign lnk.buffer_read_enable = st_r.rd_en;
  assign lnk.buffer_read_address = {st_r.rd_addr, st_r.rd_addr};
  assign lnk.buffer_end_stop_control =
    {st_r.ctrl[`RXP_CTRL_STOP1], st_r.ctrl[`RXP_CTRL_STOP0]};
  assign lnk.empty_flag_type_select = st_r.empty_sel;
  assign lnk.status_port_number = st_r.port_num;
  assign lnk.port_flow_status_in = st_r.port_stat;
  assign lnk.status_mem_write_enable = st_r.stat_we;
  assign lnk.status_mem_write_clock = st_r.stat_we;
  assign lnk.external_status_select = st_r.ctrl[`RXP_CTRL_EXT];
  // dynamic alignment mode holds the insert select at zero
  assign lnk.rx_clock_delay_insert =
    st_r.ctrl[`RXP_CTRL_INSERT] && !st_r.ctrl[`RXP_CTRL_DYN];
  assign lnk.rx_clock_delay_tap =
    st_r.ctrl[`RXP_CTRL_TAP_HI:`RXP_CTRL_TAP_LO];
endmodule : rxp_host

// ===== dv/rxp_props.sv
`timescale 1ns/1ps
`include "rxp_consts.svh"
module rxp_props (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [1:0] buffer_read_enable,
  input wire logic [1:0] buffer_empty_flag,
  input wire logic rx_status_quarter_clock,
  input wire logic status_mem_write_enable,
  input wire logic status_mem_write_clock,
  input wire logic [2:0] rx_clock_delay_tap
);
  // one domain, reset disables every check
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  chk_tap_legal:
    assert property (rx_clock_delay_tap <= `RXP_TAP_MAX)
    else $error("delay tap above six");
  chk_read_nonempty0:
    assert property (buffer_read_enable[0] |-> !buffer_empty_flag[0])
    else $error("buffer 0 read while empty");
  chk_read_nonempty1:
    assert property (buffer_read_enable[1] |-> !buffer_empty_flag[1])
    else $error("buffer 1 read while empty");
  chk_quarter_spacing:
    assert property (rx_status_quarter_clock |=>
      !rx_status_quarter_clock [*3])
    else $error("status clock faster than a quarter");
  chk_write_pulse:
    assert property (status_mem_write_enable |=> !status_mem_write_enable)
    else $error("status write enable longer than a cycle");
  chk_write_clocked:
    assert property (status_mem_write_enable == status_mem_write_clock)
    else $error("status write enable without its clock");
  chk_read_spacing:
    assert property (buffer_read_enable != 2'b00 |=>
      buffer_read_enable == 2'b00 [*2])
    else $error("reads closer than three cycles");
  chk_read_single:
    assert property ($onehot0(buffer_read_enable))
    else $error("two buffers read at once");
endmodule : rxp_props

// ===== dv/packet_rx_fifo_read_and_status_port_tb.sv
`timescale 1ns/1ps
`include "rxp_consts.svh"
module packet_rx_fifo_read_and_status_port_tb;
  import rxp_pkg::*;
  logic sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr, irq;
  logic [19:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic in_valid, in_buffer, tick, delay_insert, err_v;
  rxp_word_t in_word;
  logic [1:0] in_ready, link_status;
  logic [7:0] link_status_port;
  logic [2:0] delay_tap;
  int n_errors, total_checks, cycles;

  // ------------------------------------------------------------
  // both ends joined across the interface
  // ------------------------------------------------------------
  rxp_if lnk_if();
  rxp_device rxp_device_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .lnk(lnk_if.dev), .in_valid(in_valid), .in_buffer(in_buffer),
    .in_word(in_word), .in_ready(in_ready), .rx_data_clock_tick(tick),
    .link_status(link_status), .link_status_port(link_status_port),
    .delay_insert(delay_insert), .delay_tap(delay_tap));
  rxp_host rxp_host_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .lnk(lnk_if.usr));
  rxp_props rxp_props_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .buffer_read_enable(lnk_if.buffer_read_enable),
    .buffer_empty_flag(lnk_if.buffer_empty_flag),
    .rx_status_quarter_clock(lnk_if.rx_status_quarter_clock),
    .status_mem_write_enable(lnk_if.status_mem_write_enable),
    .status_mem_write_clock(lnk_if.status_mem_write_clock),
    .rx_clock_delay_tap(lnk_if.rx_clock_delay_tap));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [63:0] seen,
    input logic [63:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop

  // one apb transfer, held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [19:0] a,
    input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1)
      @(posedge sys_clk);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic push(input logic b, input rxp_word_t w);
    @(posedge sys_clk);
    in_valid <= 1'b1;
    in_buffer <= b;
    in_word <= w;
    @(posedge sys_clk);
    in_valid <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask : push

  // read command, then wait out the capture latency
  task automatic read_slot(input logic b, input logic [2:0] a);
    apb(1'b1, `RXP_OFF_RDCMD, {28'h0, b, a});
    repeat (3) @(posedge sys_clk);
  endtask : read_slot

  // word i carries one byte enable, and one marker for i below four
  function automatic rxp_word_t mk(input int i);
    rxp_word_t w;
    w = '0;
    w.data = 64'h0123_4567_89ab_cdef + 64'(i);
    w.be = 8'h80 >> i;
    {w.ctl, w.sop, w.eop, w.err} = 4'h8 >> i;
    return w;
  endfunction : mk

  // wait for the calendar to come round to port p afresh
  task automatic wait_port(input logic [7:0] p);
    bit left;
    left = 1'b0;
    // let a just-launched status write reach the memory first
    repeat (2) @(posedge sys_clk);
    for (int k = 0; k < 3000; k++)
    begin
      @(posedge sys_clk);
      if (left && link_status_port === p)
        break;
      if (link_status_port !== p)
        left = 1'b1;
    end
  endtask : wait_port

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_refuse();
    check("empty_rst", lnk_if.buffer_empty_flag, 2'b11);
    apb(1'b0, 20'h00100, '0);
    check("unmapped_err", err_v, 1'b1);
    check("unmapped_data", rd_v, 32'h0);
    read_slot(1'b0, 3'h0);
    apb(1'b0, `RXP_OFF_IRQST, '0);
    check("refused", rd_v, 32'h2);
    check("irq_masked", irq, 1'b0);
  endtask : t_refuse

  task automatic t_markers();
    rxp_word_t w;
    logic [3:0] m;
    apb(1'b1, `RXP_OFF_IRQMSK, 32'h5);
    for (int i = 0; i < 4; i++)
      push(1'b0, mk(i));
    for (int i = 0; i < 4; i++)
    begin
      w = mk(i);
      read_slot(1'b0, 3'(i));
      m = {lnk_if.buffer_port_id_marker[0], lnk_if.buffer_packet_start[0],
        lnk_if.buffer_packet_end[0], lnk_if.buffer_word_error[0]};
      check("word", lnk_if.buffer_read_word[0], w.data);
      check("be", lnk_if.buffer_byte_enables[0], w.be);
      check("mark", m, 4'h8 >> i);
      apb(1'b0, `RXP_OFF_DATLO, '0);
      check("datlo", rd_v, w.data[31:0]);
      apb(1'b0, `RXP_OFF_DATHI, '0);
      check("dathi", rd_v, w.data[63:32]);
      apb(1'b0, `RXP_OFF_MARK, '0);
      check("mark_reg", rd_v, {20'h0, w.ctl, w.err, w.eop, w.sop, w.be});
      check("irq_set", irq, 1'b1);
      apb(1'b0, `RXP_OFF_IRQST, '0);
      check("irqst", rd_v, {29'h0, w.err, 2'b01});
      repeat (2) @(posedge sys_clk);
      check("irq_clear", irq, 1'b0);
    end
    check("drained", lnk_if.buffer_empty_flag[0], 1'b1);
  endtask : t_markers

  task automatic t_empty_type();
    rxp_word_t w;
    w = mk(6);
    apb(1'b1, `RXP_OFF_EMPTYSEL, 32'h1);
    push(1'b0, mk(4));
    check("below_quarter", lnk_if.buffer_empty_flag[0], 1'b1);
    push(1'b0, mk(5));
    check("at_quarter", lnk_if.buffer_empty_flag[0], 1'b0);
    push(1'b1, mk(6));
    check("true_empty", lnk_if.buffer_empty_flag[1], 1'b0);
    read_slot(1'b1, 3'h0);
    apb(1'b0, `RXP_OFF_DATLO, '0);
    check("buf1_word", rd_v, w.data[31:0]);
  endtask : t_empty_type

  task automatic t_status();
    apb(1'b1, `RXP_OFF_CTRL, 32'h1);
    apb(1'b1, `RXP_OFF_STCMD, 32'h105);
    wait_port(8'h05);
    check("ext_status", link_status, 2'h1);
    apb(1'b1, `RXP_OFF_CTRL, 32'h0);
    wait_port(8'h05);
    check("int_status", link_status, `RXP_STAT_STARVING);
    // fill buffer 0: a full buffer reports satisfied on its ports
    for (int i = 0; i < 6; i++)
      push(1'b0, mk(i));
    check("room", in_ready, 2'b10);
    wait_port(8'h04);
    check("full_status", link_status, `RXP_STAT_SATISFIED);
  endtask : t_status

  task automatic t_delay();
    apb(1'b1, `RXP_OFF_CTRL, 32'h62);
    repeat (3) @(posedge sys_clk);
    check("insert_on", delay_insert, 1'b1);
    check("tap3", delay_tap, 3'h3);
    apb(1'b1, `RXP_OFF_CTRL, 32'he6);
    repeat (3) @(posedge sys_clk);
    check("insert_dyn", delay_insert, 1'b0);
    check("tap_clamp", lnk_if.rx_clock_delay_tap, 3'h6);
    check("tap_dev", delay_tap, 3'h6);
  endtask : t_delay

  // clock source
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // hang guard
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      report_and_stop();
    end
  end

  // main sequence
  initial
  begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    in_valid = 1'b0;
    in_buffer = 1'b0;
    in_word = '0;
    tick = 1'b1;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_refuse();
    t_markers();
    t_empty_type();
    t_status();
    t_delay();
    report_and_stop();
  end
endmodule : packet_rx_fifo_read_and_status_port_tb
